// File: esc_params.svh
// constants shared by the engine status codec ends
`ifndef ESC_PARAMS_SVH
`define ESC_PARAMS_SVH

// core clock rate in hertz and cycles per millisecond
`define ESC_CLK_HZ 20000000
`define ESC_CYC_PER_MS (`ESC_CLK_HZ / 1000)

// maximum data delay of each signal, in milliseconds
`define ESC_DLY_FUEL_MS 250
`define ESC_DLY_STOP_MS 1025
`define ESC_DLY_ENRICH_MS 500
`define ESC_DLY_IDLE_MS 125
`define ESC_DLY_BOOST_MS 125
`define ESC_DLY_IAT_MS 525

// cycles kept back from each refresh period to cover arbitration and link latency
`define ESC_ARB_SLACK 8

// refresh counter width, enough for the longest delay
`define ESC_CNT_W 25

// number of signal groups on the link
`define ESC_NSIG 6

// link payload layout: value in the low byte, validity on top
`define ESC_DATA_W 9
`define ESC_VAL_LSB 0
`define ESC_VAL_MSB 7
`define ESC_INVALID_BIT 8

// validity encodings
`define ESC_VALID 1'h0
`define ESC_INVALID 1'h1

`endif

// File: esc_pkg.sv
// types shared by both ends of the engine status codec
package esc_pkg;
    `include "esc_params.svh"

    // signal groups, listed from lowest to highest send priority
    typedef enum logic [2:0] {
        ESC_SIG_FUEL,
        ESC_SIG_STOP,
        ESC_SIG_ENRICH,
        ESC_SIG_IDLE,
        ESC_SIG_BOOST,
        ESC_SIG_IAT
    } esc_sig_t;

    // closed-loop readiness levels, in their coded order
    typedef enum logic [1:0] {
        ESC_FUEL_OPEN,
        ESC_FUEL_NONSTOICH,
        ESC_FUEL_STOICH
    } esc_fuel_t;

    // transmitter state
    typedef struct packed {
        logic [`ESC_NSIG-1:0][`ESC_CNT_W-1:0] cnt;
        logic [`ESC_NSIG-1:0] pend;
        logic link_valid;
        esc_sig_t link_sig;
        logic [`ESC_DATA_W-1:0] link_data;
        logic crank_ok;
        logic thr_err;
    } esc_tx_state_t;

    // receiver state
    typedef struct packed {
        esc_fuel_t fuel;
        logic adapt_inhibit;
        logic stop;
        logic stop_lamp;
        logic enrich;
        logic idle;
        logic [7:0] boost;
        logic boost_ok;
        logic [7:0] iat;
        logic iat_ok;
        logic iat_seen;
    } esc_rx_state_t;
endpackage

// File: esc_link_if.sv
// link between the engine controller end and the body controller end
`timescale 1ns/1ps
`include "esc_params.svh"
interface esc_link_if;
    import esc_pkg::*;
    logic valid;
    esc_sig_t sig;
    logic [`ESC_DATA_W-1:0] data;

    modport tx (output valid, output sig, output data);
    modport rx (input valid, input sig, input data);
endinterface

// File: esc_engine_tx.sv
// engine controller end: builds status signals and refreshes them on the link
`timescale 1ns/1ps
`include "esc_params.svh"

module esc_engine_tx #(
    parameter int unsigned P_FUEL_CYC = `ESC_DLY_FUEL_MS * `ESC_CYC_PER_MS,
    parameter int unsigned P_STOP_CYC = `ESC_DLY_STOP_MS * `ESC_CYC_PER_MS,
    parameter int unsigned P_ENRICH_CYC = `ESC_DLY_ENRICH_MS * `ESC_CYC_PER_MS,
    parameter int unsigned P_IDLE_CYC = `ESC_DLY_IDLE_MS * `ESC_CYC_PER_MS,
    parameter int unsigned P_BOOST_CYC = `ESC_DLY_BOOST_MS * `ESC_CYC_PER_MS,
    parameter int unsigned P_IAT_CYC = `ESC_DLY_IAT_MS * `ESC_CYC_PER_MS
) (
    // clock and reset
    input logic i_core_clk,
    input logic i_arst_n,
    // fuel control readiness
    input esc_pkg::esc_fuel_t i_fuel_ready,
    // coolant temperature and calibrated thresholds
    input logic [7:0] i_coolant_temp,
    input logic [7:0] i_stop_thr,
    input logic [7:0] i_enrich_thr,
    // hot fuel enrichment control
    input logic i_enrich_enable,
    input logic i_enriching,
    // idle status
    input logic i_engine_running,
    input logic i_air_idle,
    // boost pressure, signed kPa gauge
    input logic [7:0] i_boost_kpa,
    input logic [7:0] i_boost_backup_kpa,
    input logic i_boost_fail,
    input logic i_boost_backup_ok,
    input logic i_boost_fault_stored,
    // intake air temperature, count is degrees plus 40
    input logic [7:0] i_iat_count,
    input logic i_iat_fail,
    input logic i_iat_fault_stored,
    // status towards the engine controller
    output logic o_crank_permit,
    output logic o_thr_error,
    // link to the body controllers
    esc_link_if.tx link
);
    import esc_pkg::*;

    esc_tx_state_t q;
    esc_tx_state_t d;

    // refresh period per signal, held back so arbitration cannot make it late
    function automatic logic [`ESC_CNT_W-1:0] period_of(input int unsigned idx);
        int unsigned cyc;
        cyc = P_FUEL_CYC;
        case (idx)
            ESC_SIG_STOP: cyc = P_STOP_CYC;
            ESC_SIG_ENRICH: cyc = P_ENRICH_CYC;
            ESC_SIG_IDLE: cyc = P_IDLE_CYC;
            ESC_SIG_BOOST: cyc = P_BOOST_CYC;
            ESC_SIG_IAT: cyc = P_IAT_CYC;
            default: cyc = P_FUEL_CYC;
        endcase
        // a short period never goes below one cycle
        if (cyc > `ESC_ARB_SLACK + 1) begin
            return `ESC_CNT_W'(cyc - `ESC_ARB_SLACK - 1);
        end else begin
            return `ESC_CNT_W'(1);
        end
    endfunction

    // stop threshold forced above enrichment threshold if calibration is wrong
    logic thr_bad;
    logic [7:0] stop_thr_eff;
    always_comb begin
        thr_bad = (i_stop_thr <= i_enrich_thr);
        if (thr_bad) begin
            // saturate: at full scale the stop flag can never assert, the safe side
            stop_thr_eff = (i_enrich_thr == 8'hff) ? 8'hff : i_enrich_thr + 8'h01;
        end else begin
            stop_thr_eff = i_stop_thr;
        end
    end

    // live signal values, sampled at the moment each one is sent
    logic stop_flag;
    logic enrich_flag;
    logic idle_flag;
    logic boost_invalid;
    logic iat_invalid;
    logic [7:0] boost_val;
    esc_fuel_t fuel_val;
    always_comb begin
        stop_flag = (i_coolant_temp > stop_thr_eff);
        // with enrichment control off only the coolant comparison counts
        enrich_flag = i_enrich_enable & i_enriching;
        enrich_flag = enrich_flag | (i_coolant_temp > i_enrich_thr);
        idle_flag = i_engine_running & i_air_idle;
        // invalid only when no backup exists and the fault is logged
        boost_invalid = i_boost_fail & ~i_boost_backup_ok & i_boost_fault_stored;
        boost_val = i_boost_fail ? i_boost_backup_kpa : i_boost_kpa;
        iat_invalid = i_iat_fail & i_iat_fault_stored;
        // unused code 3 is never sent; fall back to the least ready level
        if (i_fuel_ready == ESC_FUEL_NONSTOICH || i_fuel_ready == ESC_FUEL_STOICH) begin
            fuel_val = i_fuel_ready;
        end else begin
            fuel_val = ESC_FUEL_OPEN;
        end
    end

    // payload for one signal group
    function automatic logic [`ESC_DATA_W-1:0] encode(input esc_sig_t sig);
        logic [`ESC_DATA_W-1:0] w;
        w = '0;
        case (sig)
            ESC_SIG_FUEL: begin
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = {6'h00, fuel_val};
            end
            ESC_SIG_STOP: begin
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = {7'h00, stop_flag};
            end
            ESC_SIG_ENRICH: begin
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = {7'h00, enrich_flag};
            end
            ESC_SIG_IDLE: begin
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = {7'h00, idle_flag};
            end
            ESC_SIG_BOOST: begin
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = boost_val;
                w[`ESC_INVALID_BIT] = boost_invalid ? `ESC_INVALID : `ESC_VALID;
            end
            ESC_SIG_IAT: begin
                // count passes through unchanged; the receiver also keeps and outputs the raw count
                w[`ESC_VAL_MSB:`ESC_VAL_LSB] = i_iat_count;
                w[`ESC_INVALID_BIT] = iat_invalid ? `ESC_INVALID : `ESC_VALID;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // next state: refresh timers, pending set, one send per cycle
    logic grant_any;
    esc_sig_t grant_sig;
    logic [`ESC_NSIG-1:0] expire;
    always_comb begin
        d = q;
        grant_any = 1'b0;
        grant_sig = ESC_SIG_FUEL;
        expire = '0;
        // later index wins, so intake air temperature has top priority
        for (int i = 0; i < `ESC_NSIG; i++) begin
            if (q.pend[i]) begin
                grant_any = 1'b1;
                grant_sig = esc_sig_t'(i);
            end
        end
        for (int i = 0; i < `ESC_NSIG; i++) begin
            if (q.cnt[i] == '0) begin
                expire[i] = 1'b1;
                d.cnt[i] = period_of(i);
            end else begin
                d.cnt[i] = q.cnt[i] - `ESC_CNT_W'(1);
            end
            // a fresh expiry in the grant cycle is kept, not lost
            d.pend[i] = (q.pend[i] & ~(grant_any & (grant_sig == esc_sig_t'(i)))) | expire[i];
        end
        d.link_valid = grant_any;
        d.link_sig = grant_sig;
        d.link_data = grant_any ? encode(grant_sig) : q.link_data;
        // cranking is allowed once the first temperature is on the link
        if (grant_any && grant_sig == ESC_SIG_IAT) begin
            d.crank_ok = 1'b1;
        end
        d.thr_err = thr_bad;
    end

    // state register; every group is pending out of reset
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.cnt <= '0;
            q.pend <= '1;
            q.link_valid <= 1'b0;
            q.link_sig <= ESC_SIG_FUEL;
            q.link_data <= '0;
            q.crank_ok <= 1'b0;
            q.thr_err <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign link.valid = q.link_valid;
    assign link.sig = q.link_sig;
    assign link.data = q.link_data;
    assign o_crank_permit = q.crank_ok;
    assign o_thr_error = q.thr_err;
endmodule

// File: esc_body_rx.sv
// body controller end: decodes status signals and drives the displays
`timescale 1ns/1ps
`include "esc_params.svh"
module esc_body_rx (
    // clock and reset
    input logic i_core_clk,
    input logic i_arst_n,
    // lamp test request from the cluster
    input logic i_bulb_check,
    // link from the engine controller
    esc_link_if.rx link,
    // fuel pump controller
    output esc_pkg::esc_fuel_t o_fuel_ready,
    output logic o_adapt_inhibit,
    // hot engine displays
    output logic o_stop_telltale,
    output logic o_stop_chime,
    output logic o_hot_telltale,
    output logic o_gauge_red_zone,
    // tachometer damping
    output logic o_tach_heavy_damp,
    // analogue values with their validity
    output logic [7:0] o_boost_kpa,
    output logic o_boost_valid,
    output logic [7:0] o_iat_count,
    output logic o_iat_valid,
    output logic o_iat_seen
);
    import esc_pkg::*;

    esc_rx_state_t q;
    esc_rx_state_t d;

    // decode one received group; invalid analogue values are not stored
    logic [7:0] val;
    logic bad;
    always_comb begin
        d = q;
        val = link.data[`ESC_VAL_MSB:`ESC_VAL_LSB];
        bad = (link.data[`ESC_INVALID_BIT] == `ESC_INVALID);
        if (link.valid) begin
            case (link.sig)
                ESC_SIG_FUEL: begin
                    d.fuel = (val[1:0] == ESC_FUEL_STOICH) ? ESC_FUEL_STOICH :
                             (val[1:0] == ESC_FUEL_NONSTOICH) ? ESC_FUEL_NONSTOICH :
                             ESC_FUEL_OPEN;
                end
                ESC_SIG_STOP: begin
                    d.stop = val[0];
                end
                ESC_SIG_ENRICH: begin
                    d.enrich = val[0];
                end
                ESC_SIG_IDLE: begin
                    d.idle = val[0];
                end
                ESC_SIG_BOOST: begin
                    // last good value is held so the gauge does not jump
                    if (!bad) begin
                        d.boost = val;
                    end
                    d.boost_ok = ~bad;
                end
                ESC_SIG_IAT: begin
                    if (!bad) begin
                        d.iat = val;
                    end
                    d.iat_ok = ~bad;
                    d.iat_seen = 1'b1;
                end
                default: begin
                    d = q;
                end
            endcase
        end
        // adaptives learn only with full stoichiometric readiness
        d.adapt_inhibit = (d.fuel != ESC_FUEL_STOICH);
        d.stop_lamp = d.stop | i_bulb_check;
    end

    // state register; values start invalid until the first frame
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.fuel <= ESC_FUEL_OPEN;
            q.adapt_inhibit <= 1'b1;
            q.stop <= 1'b0;
            q.stop_lamp <= 1'b0;
            q.enrich <= 1'b0;
            q.idle <= 1'b0;
            q.boost <= 8'h00;
            q.boost_ok <= 1'b0;
            q.iat <= 8'h00;
            q.iat_ok <= 1'b0;
            q.iat_seen <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs from the state register; hot display has no added delay
    assign o_fuel_ready = q.fuel;
    assign o_adapt_inhibit = q.adapt_inhibit;
    assign o_stop_telltale = q.stop_lamp;
    assign o_stop_chime = q.stop;
    assign o_hot_telltale = q.enrich;
    assign o_gauge_red_zone = q.enrich;
    assign o_tach_heavy_damp = q.idle;
    assign o_boost_kpa = q.boost;
    assign o_boost_valid = q.boost_ok;
    assign o_iat_count = q.iat;
    assign o_iat_valid = q.iat_ok;
    assign o_iat_seen = q.iat_seen;
endmodule

// File: esc_link_monitor.sv
// link checker: payload shapes, startup order and refresh age of each group
`timescale 1ns/1ps
`include "esc_params.svh"
module esc_link_monitor #(
    parameter int unsigned P_FUEL_CYC = 120,
    parameter int unsigned P_STOP_CYC = 160,
    parameter int unsigned P_ENRICH_CYC = 100,
    parameter int unsigned P_IDLE_CYC = 40,
    parameter int unsigned P_BOOST_CYC = 50,
    parameter int unsigned P_IAT_CYC = 140
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // link signals
    input wire logic valid,
    input wire esc_pkg::esc_sig_t sig,
    input wire logic [`ESC_DATA_W-1:0] data
);
    import esc_pkg::*;
    logic [3:0] cyc_q;
    logic [5:0][15:0] gap_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    // counters clear on reset, so age checks restart with the startup burst
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc_q <= 4'h0;
            gap_q <= '0;
        end else begin
            if (cyc_q != 4'hf) begin
                cyc_q <= cyc_q + 4'h1;
            end
            for (int g = 0; g < 6; g++) begin
                gap_q[g] <= (valid && sig == 3'(g)) ? 16'h0000 : gap_q[g] + 16'h0001;
            end
        end
    end

    // one frame of a given group
    sequence s_fr(esc_sig_t g);
        valid && sig == g;
    endsequence

    first_iat_a: assert property (cyc_q == 4'h1 |-> s_fr(ESC_SIG_IAT))
        else $error("first frame after reset is not air temperature");
    // temperature goes twice: its timer also expires on the edge of its first grant
    start_order_a: assert property (cyc_q == 4'h2 |-> s_fr(ESC_SIG_IAT) ##1
        s_fr(ESC_SIG_BOOST) ##1 s_fr(ESC_SIG_IDLE) ##1 s_fr(ESC_SIG_ENRICH) ##1
        s_fr(ESC_SIG_STOP) ##1 s_fr(ESC_SIG_FUEL))
        else $error("startup burst out of order");
    fuel_code_a: assert property (s_fr(ESC_SIG_FUEL) |->
        data[8:2] == 7'h00 && data[1:0] != 2'h3)
        else $error("fuel readiness code out of range");
    stop_flag_a: assert property (s_fr(ESC_SIG_STOP) |-> data[8:1] == 8'h00)
        else $error("stop flag payload wider than one bit");
    enrich_flag_a: assert property (s_fr(ESC_SIG_ENRICH) |-> data[8:1] == 8'h00)
        else $error("enrichment flag payload wider than one bit");
    idle_flag_a: assert property (s_fr(ESC_SIG_IDLE) |-> data[8:1] == 8'h00)
        else $error("idle flag payload wider than one bit");
    idle_fresh_a: assert property (gap_q[ESC_SIG_IDLE] < P_IDLE_CYC)
        else $error("idle frame older than its delay");
    boost_fresh_a: assert property (gap_q[ESC_SIG_BOOST] < P_BOOST_CYC)
        else $error("boost frame older than its delay");
    fuel_fresh_a: assert property (gap_q[ESC_SIG_FUEL] < P_FUEL_CYC)
        else $error("fuel frame older than its delay");
    iat_fresh_a: assert property (gap_q[ESC_SIG_IAT] < P_IAT_CYC)
        else $error("temperature frame older than its delay");
    stop_fresh_a: assert property (gap_q[ESC_SIG_STOP] < P_STOP_CYC)
        else $error("stop frame older than its delay");
    enrich_fresh_a: assert property (gap_q[ESC_SIG_ENRICH] < P_ENRICH_CYC)
        else $error("enrichment frame older than its delay");
endmodule

// File: engine_status_signal_codec_tb.sv
// bench joining both codec ends over the link, with table rows and edge cases
`timescale 1ns/1ps
`include "esc_params.svh"
`define CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module engine_status_signal_codec_tb;
    import esc_pkg::*;
    localparam int unsigned P_FUEL = 120;
    localparam int unsigned P_IDLE = 40;
    localparam int unsigned P_BOOST = 50;
    localparam int unsigned P_IAT = 140;
    localparam int unsigned P_STOP = 160;
    localparam int unsigned P_ENRICH = 100;
    // ctl = {enable, enriching, running, air idle}; flags = {inhibit, stop, hot, idle}
    typedef struct packed {
        logic [1:0] fuel;
        logic [7:0] cool;
        logic [3:0] ctl;
        logic [7:0] bst;
        logic [7:0] bk;
        logic [2:0] bctl;
        logic [7:0] iat;
        logic [1:0] ictl;
        logic [1:0] e_fuel;
        logic [3:0] e_flg;
        logic [7:0] e_bst;
        logic [7:0] e_iat;
        logic [1:0] e_vld;
    } esc_row_t;
    // thresholds stop c8 and enrich a0 for every row
    esc_row_t rows [5] = '{
        '{2'h0, 8'h50, 4'hb, 8'h10, 8'h7f, 3'h0, 8'h41, 2'h0, 2'h0, 4'h9, 8'h10, 8'h41, 2'h3},
        '{2'h1, 8'ha1, 4'ha, 8'h80, 8'h7f, 3'h0, 8'h00, 2'h0, 2'h1, 4'ha, 8'h80, 8'h00, 2'h3},
        '{2'h2, 8'hc9, 4'h9, 8'h33, 8'h7f, 3'h6, 8'hff, 2'h0, 2'h2, 4'h6, 8'h7f, 8'hff, 2'h3},
        '{2'h3, 8'h20, 4'hf, 8'h05, 8'h7f, 3'h5, 8'h12, 2'h3, 2'h0, 4'hb, 8'h7f, 8'hff, 2'h0},
        '{2'h2, 8'h20, 4'h7, 8'h05, 8'he0, 3'h4, 8'h12, 2'h2, 2'h2, 4'h1, 8'he0, 8'h12, 2'h3}
    };
    logic clk;
    logic rst_n;
    esc_fuel_t fuel;
    esc_fuel_t o_fuel;
    logic [7:0] cool, stop_thr, enr_thr, bst, bk, iat, o_bst, o_iat;
    logic en, enr, run, air, bf, bok, bflt, ifl, iflt, bulb;
    logic crank, thr_err, inh, stop_tt, chime, hot_tt, red, tach, bv, iv, seen;
    int n_fail = 0;
    int compares = 0;

    esc_link_if esc_link_if_inst();
    esc_engine_tx #(.P_FUEL_CYC(P_FUEL), .P_STOP_CYC(P_STOP), .P_ENRICH_CYC(P_ENRICH),
        .P_IDLE_CYC(P_IDLE), .P_BOOST_CYC(P_BOOST), .P_IAT_CYC(P_IAT)) esc_engine_tx_inst (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_fuel_ready(fuel), .i_coolant_temp(cool),
        .i_stop_thr(stop_thr), .i_enrich_thr(enr_thr), .i_enrich_enable(en), .i_enriching(enr),
        .i_engine_running(run), .i_air_idle(air), .i_boost_kpa(bst), .i_boost_backup_kpa(bk),
        .i_boost_fail(bf), .i_boost_backup_ok(bok), .i_boost_fault_stored(bflt),
        .i_iat_count(iat), .i_iat_fail(ifl), .i_iat_fault_stored(iflt),
        .o_crank_permit(crank), .o_thr_error(thr_err), .link(esc_link_if_inst));
    esc_body_rx esc_body_rx_inst (.i_core_clk(clk), .i_arst_n(rst_n), .i_bulb_check(bulb),
        .link(esc_link_if_inst), .o_fuel_ready(o_fuel), .o_adapt_inhibit(inh),
        .o_stop_telltale(stop_tt), .o_stop_chime(chime), .o_hot_telltale(hot_tt),
        .o_gauge_red_zone(red), .o_tach_heavy_damp(tach), .o_boost_kpa(o_bst),
        .o_boost_valid(bv), .o_iat_count(o_iat), .o_iat_valid(iv), .o_iat_seen(seen));
    esc_link_monitor #(.P_FUEL_CYC(P_FUEL), .P_STOP_CYC(P_STOP), .P_ENRICH_CYC(P_ENRICH),
        .P_IDLE_CYC(P_IDLE), .P_BOOST_CYC(P_BOOST), .P_IAT_CYC(P_IAT))
        esc_link_monitor_inst (.i_core_clk(clk), .i_arst_n(rst_n),
        .valid(esc_link_if_inst.valid), .sig(esc_link_if_inst.sig), .data(esc_link_if_inst.data));

    // 20 MHz core clock
    always #25 clk = ~clk;

    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // waits longer than the slowest refresh so every group has been resent
    task automatic apply(input esc_row_t r);
        fuel <= esc_fuel_t'(r.fuel);
        cool <= r.cool;
        {en, enr, run, air} <= r.ctl;
        bst <= r.bst;
        bk <= r.bk;
        {bf, bok, bflt} <= r.bctl;
        iat <= r.iat;
        {ifl, iflt} <= r.ictl;
        repeat (200) @(posedge clk);
        `CHK("fuel", r.e_fuel, o_fuel)
        `CHK("inhibit", r.e_flg[3], inh)
        `CHK("stop", r.e_flg[2], stop_tt)
        `CHK("chime", r.e_flg[2], chime)
        `CHK("hot", r.e_flg[1], hot_tt)
        `CHK("red", r.e_flg[1], red)
        `CHK("tach", r.e_flg[0], tach)
        `CHK("boost", r.e_bst, o_bst)
        `CHK("boost ok", r.e_vld[1], bv)
        `CHK("iat", r.e_iat, o_iat)
        `CHK("iat ok", r.e_vld[0], iv)
        `CHK("thr ok", 1'h0, thr_err)
    endtask

    // hang guard, far beyond the expected run of about 1230 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        fuel = ESC_FUEL_OPEN;
        {cool, bst, bk, iat} = 32'h0000_0000;
        stop_thr = 8'hc8;
        enr_thr = 8'ha0;
        {en, enr, run, air, bf, bok, bflt, ifl, iflt, bulb} = 10'h000;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            apply(rows[i]);
        end
        // lamp test lights the stop telltale but must not sound the chime
        bulb <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK("bulb tt", 1'h1, stop_tt)
        `CHK("bulb chime", 1'h0, chime)
        bulb <= 1'h0;
        // equal thresholds: stop is forced just above enrichment and flagged
        stop_thr <= 8'ha0;
        cool <= 8'ha5;
        repeat (200) @(posedge clk);
        `CHK("thr err", 1'h1, thr_err)
        `CHK("forced stop", 1'h1, chime)
        // second reset in mid-run, then the temperature goes out first
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        `CHK("rst crank", 1'h0, crank)
        `CHK("rst seen", 1'h0, seen)
        `CHK("rst inhibit", 1'h1, inh)
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK("crank", 1'h1, crank)
        repeat (2) @(posedge clk);
        `CHK("seen", 1'h1, seen)
        `CHK("first iat", 8'h12, o_iat)
        stop_test();
    end
endmodule
